// file: design/charger_config_regs_0c_0f.sv
// charger configuration and status registers at offsets 0x0C to 0x0F
// assumes an i2c slave front end delivering byte reads and writes,
// and analog loops that take the registered limits below
// How it works
// - cool cap limits charge voltage to 4.1V before trim
// - cool zone charging needs allow bit set
// - warm zone current scaled 0, 1/5, 1/2, full
// - warm zone never doubles the safety timer
// - cool threshold from two-bit code, default 01
// - warm threshold from two-bit code, default 01
// - pulse requests only while pulse control allowed
// - pulse request bits self-clear when sequence ends
// - dplus level code, high impedance at reset
// - dminus level code, same encoding as dplus
// - line levels default on plug-in; host waits
// - boost frequency 500kHz at 0, 1.5MHz at 1
// - charge mode: termination times six above 300mA
// - detect done flag set when detection finishes
// - charge voltage trim +8, -8, -16 mV
// - trickle current 90mA at 0, 30mA at 1
// - status pin off, low, or two blink patterns
// - status pattern only when monitor select is 01
// - input regulation offset 3.9 to 10.5V
// - register reset restores defaults, restarts safety timer
`timescale 1ns/1ps
`include "charger_regs.svh"
module charger_config_regs_0c_0f #(
   parameter int unsigned BLINK_ON_CYCLES = `BLINK_ON_CYCLES,
   parameter int unsigned BLINK_OFF_SHORT_CYCLES = `BLINK_OFF_SHORT_CYCLES,
   parameter int unsigned BLINK_OFF_LONG_CYCLES = `BLINK_OFF_LONG_CYCLES
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   input wire logic reg_reset_i,
   input wire logic watchdog_expire_i,
   input wire logic zone_cool_i,
   input wire logic zone_warm_i,
   input wire logic boost_mode_i,
   input wire logic [12:0] target_mv_i,
   input wire logic [12:0] charge_current_setting_ma_i,
   input wire logic [12:0] termination_current_setting_ma_i,
   input wire logic timer_double_req_i,
   input wire logic pulse_done_i,
   input wire logic source_plugin_i,
   input wire logic force_detect_i,
   input wire logic detect_finish_i,
   input wire logic [1:0] monitor_select_i,
   output logic [12:0] charge_mv_o,
   output logic [12:0] charge_ma_o,
   output logic [12:0] term_ma_o,
   output logic [6:0] trickle_ma_o,
   output logic timer_double_o,
   output logic timer_restart_o,
   output logic [1:0] cool_select_o,
   output logic [1:0] warm_select_o,
   output logic pulse_allow_o,
   output logic pulse_raise_o,
   output logic pulse_lower_o,
   output logic [1:0] dplus_level_o,
   output logic [1:0] dminus_level_o,
   output logic boost_fast_o,
   output logic [1:0] input_offset_o,
   output logic stat_out_o,
   output logic stat_oe_o
);
   logic [7:0] temp_zone_charge_config_r;
   logic [7:0] pulse_and_usb_line_config_r;
   logic [7:0] trim_and_pin_config_r;
   logic source_detect_complete_r;
   logic wr_temp;
   logic wr_pulse;
   logic wr_trim;
   logic defaults;
   logic [12:0] capped_mv;
   logic [12:0] trimmed_mv;
   logic [12:0] scaled_ma;
   charger_pkg::code2_t warm_zone_current_scale;
   charger_pkg::code2_t charge_voltage_trim;
   stat_pin_if stat_ctl();

   // write decode and the common restore condition
   assign wr_temp = reg_wr_i && reg_addr_i == `OFS_TEMP_ZONE;
   assign wr_pulse = reg_wr_i && reg_addr_i == `OFS_PULSE_LINE;
   assign wr_trim = reg_wr_i && reg_addr_i == `OFS_TRIM_PIN;
   assign defaults = reg_reset_i || watchdog_expire_i;
   assign warm_zone_current_scale = temp_zone_charge_config_r[`F_WARM_HI:`F_WARM_LO];
   assign charge_voltage_trim = trim_and_pin_config_r[`F_TRIM_HI:`F_TRIM_LO];

   // temperature zone configuration
   always_ff @(posedge clock_i) begin
      if (!resetn_i || defaults) begin
         temp_zone_charge_config_r <= `RST_TEMP_ZONE;
      end else if (wr_temp) begin
         temp_zone_charge_config_r <= reg_wdata_i;
      end
   end

   // pulse allow and frequency/range bit
   always_ff @(posedge clock_i) begin
      if (!resetn_i || defaults) begin
         pulse_and_usb_line_config_r[`F_PULSE_ALLOW] <= 1'b0;
         pulse_and_usb_line_config_r[`F_FREQ_RANGE] <= 1'b1;
      end else if (wr_pulse) begin
         pulse_and_usb_line_config_r[`F_PULSE_ALLOW] <= reg_wdata_i[`F_PULSE_ALLOW];
         pulse_and_usb_line_config_r[`F_FREQ_RANGE] <= reg_wdata_i[`F_FREQ_RANGE];
      end
   end

   // line levels fall back to high impedance on plug-in
   always_ff @(posedge clock_i) begin
      if (!resetn_i || defaults || source_plugin_i) begin
         pulse_and_usb_line_config_r[`F_DPLUS_HI:`F_DMINUS_LO] <= 4'h0;
      end else if (wr_pulse) begin
         pulse_and_usb_line_config_r[`F_DPLUS_HI:`F_DMINUS_LO] <= reg_wdata_i[`F_DPLUS_HI:`F_DMINUS_LO];
      end
   end

   // pulse requests: set needs the allow bit, a host set beats sequence end
   always_ff @(posedge clock_i) begin
      if (!resetn_i || defaults) begin
         pulse_and_usb_line_config_r[`F_PULSE_RAISE:`F_PULSE_LOWER] <= 2'h0;
      end else if (wr_pulse) begin
         pulse_and_usb_line_config_r[`F_PULSE_RAISE:`F_PULSE_LOWER] <=
            reg_wdata_i[`F_PULSE_ALLOW] ? reg_wdata_i[`F_PULSE_RAISE:`F_PULSE_LOWER] : 2'h0;
      end else if (pulse_done_i) begin
         pulse_and_usb_line_config_r[`F_PULSE_RAISE:`F_PULSE_LOWER] <= 2'h0;
      end
   end

   // trim and pin configuration; offset survives the watchdog
   always_ff @(posedge clock_i) begin
      if (!resetn_i || defaults) begin
         trim_and_pin_config_r[7:2] <= 6'h00;
      end else if (wr_trim) begin
         trim_and_pin_config_r[7:2] <= reg_wdata_i[7:2];
      end
   end

   // input regulation offset, restored only by register reset
   always_ff @(posedge clock_i) begin
      if (!resetn_i || reg_reset_i) begin
         trim_and_pin_config_r[`F_OFFSET_HI:`F_OFFSET_LO] <= 2'h0;
      end else if (wr_trim) begin
         trim_and_pin_config_r[`F_OFFSET_HI:`F_OFFSET_LO] <= reg_wdata_i[`F_OFFSET_HI:`F_OFFSET_LO];
      end
   end

   // detection done flag: cleared by a new attach or forced request, finish wins
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         source_detect_complete_r <= 1'b0;
      end else if (detect_finish_i) begin
         source_detect_complete_r <= 1'b1;
      end else if (source_plugin_i || force_detect_i) begin
         source_detect_complete_r <= 1'b0;
      end
   end

   // read data, zero for unmapped offsets and the reserved bits of 0x0E; bit 5 of 0x0F reads back as written
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         unique case (reg_addr_i)
            `OFS_TEMP_ZONE: reg_rdata_o <= temp_zone_charge_config_r;
            `OFS_PULSE_LINE: reg_rdata_o <= pulse_and_usb_line_config_r;
            `OFS_DETECT: reg_rdata_o <= {source_detect_complete_r, 7'h00};
            `OFS_TRIM_PIN: reg_rdata_o <= trim_and_pin_config_r;
            default: reg_rdata_o <= 8'h00;
         endcase
      end
   end

   // charge voltage: cool zone cap, then fine trim
   always_comb begin
      capped_mv = target_mv_i;
      if (zone_cool_i && temp_zone_charge_config_r[`F_VCAP] && target_mv_i > `VCAP_MV) begin
         capped_mv = `VCAP_MV;
      end
      unique case (charge_voltage_trim)
         2'h0: trimmed_mv = capped_mv;
         2'h1: trimmed_mv = capped_mv + `TRIM_STEP_MV;
         2'h2: trimmed_mv = capped_mv - `TRIM_STEP_MV;
         2'h3: trimmed_mv = capped_mv - (`TRIM_STEP_MV << 1);
      endcase
   end

   // charge current per zone
   always_comb begin
      scaled_ma = charge_current_setting_ma_i;
      if (zone_cool_i && !temp_zone_charge_config_r[`F_COOL_ALLOW]) begin
         scaled_ma = 13'h0000;
      end else if (zone_warm_i) begin
         unique case (warm_zone_current_scale)
            2'h0: scaled_ma = 13'h0000;
            2'h1: scaled_ma = charge_current_setting_ma_i / 13'h0005;
            2'h2: scaled_ma = charge_current_setting_ma_i >> 1;
            2'h3: scaled_ma = charge_current_setting_ma_i;
         endcase
      end
   end

   // registered analog controls
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         charge_mv_o <= 13'h0000;
         charge_ma_o <= 13'h0000;
         term_ma_o <= 13'h0000;
         trickle_ma_o <= `TRICKLE_HIGH_MA;
         timer_double_o <= 1'b0;
      end else begin
         charge_mv_o <= trimmed_mv;
         charge_ma_o <= scaled_ma;
         if (!boost_mode_i && !pulse_and_usb_line_config_r[`F_FREQ_RANGE] && charge_current_setting_ma_i > `TERM_RANGE_MIN_MA) begin
            term_ma_o <= 13'(termination_current_setting_ma_i * `TERM_RANGE_MULT);
         end else begin
            term_ma_o <= termination_current_setting_ma_i;
         end
         trickle_ma_o <= trim_and_pin_config_r[`F_TRICKLE] ? `TRICKLE_LOW_MA : `TRICKLE_HIGH_MA;
         timer_double_o <= timer_double_req_i && !zone_warm_i;
      end
   end

   // registered selections and request mirrors
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         timer_restart_o <= 1'b0;
         cool_select_o <= 2'h1;
         warm_select_o <= 2'h1;
         pulse_allow_o <= 1'b0;
         pulse_raise_o <= 1'b0;
         pulse_lower_o <= 1'b0;
         dplus_level_o <= 2'h0;
         dminus_level_o <= 2'h0;
         boost_fast_o <= 1'b1;
         input_offset_o <= 2'h0;
      end else begin
         timer_restart_o <= reg_reset_i;
         cool_select_o <= temp_zone_charge_config_r[`F_COOL_TH_HI:`F_COOL_TH_LO];
         warm_select_o <= temp_zone_charge_config_r[`F_WARM_TH_HI:`F_WARM_TH_LO];
         pulse_allow_o <= pulse_and_usb_line_config_r[`F_PULSE_ALLOW];
         pulse_raise_o <= pulse_and_usb_line_config_r[`F_PULSE_RAISE];
         pulse_lower_o <= pulse_and_usb_line_config_r[`F_PULSE_LOWER];
         dplus_level_o <= pulse_and_usb_line_config_r[`F_DPLUS_HI:`F_DPLUS_LO];
         dminus_level_o <= pulse_and_usb_line_config_r[`F_DMINUS_HI:`F_DMINUS_LO];
         boost_fast_o <= pulse_and_usb_line_config_r[`F_FREQ_RANGE];
         input_offset_o <= trim_and_pin_config_r[`F_OFFSET_HI:`F_OFFSET_LO];
      end
   end

   // status pin pattern, gated by the monitor selection
   assign stat_ctl.pattern = charger_pkg::stat_pattern_t'(trim_and_pin_config_r[`F_STAT_HI:`F_STAT_LO]);
   assign stat_ctl.active = monitor_select_i == 2'h1;
   assign stat_oe_o = stat_ctl.pin_oe;
   assign stat_out_o = stat_ctl.pin_out;

   stat_blinker #(
      .ON_CYCLES(BLINK_ON_CYCLES),
      .OFF_SHORT_CYCLES(BLINK_OFF_SHORT_CYCLES),
      .OFF_LONG_CYCLES(BLINK_OFF_LONG_CYCLES)
   ) u_stat_blinker (
      .clock_i(clock_i),
      .resetn_i(resetn_i),
      .ctl(stat_ctl.led)
   );

   property p_cool_cap;
      @(posedge clock_i) disable iff (!resetn_i)
         zone_cool_i && temp_zone_charge_config_r[`F_VCAP] && charge_voltage_trim == 2'h0
         && target_mv_i > `VCAP_MV |=> charge_mv_o == `VCAP_MV;
   endproperty
   a_cool_cap: assert property (p_cool_cap) else $error("cool cap not applied");

   property p_cool_block;
      @(posedge clock_i) disable iff (!resetn_i)
         zone_cool_i && !temp_zone_charge_config_r[`F_COOL_ALLOW] |=> charge_ma_o == 13'h0000;
   endproperty
   a_cool_block: assert property (p_cool_block) else $error("cool charge not blocked");

   property p_warm_half;
      @(posedge clock_i) disable iff (!resetn_i)
         zone_warm_i && !zone_cool_i && warm_zone_current_scale == 2'h2 |=> charge_ma_o == $past(charge_current_setting_ma_i) >> 1;
   endproperty
   a_warm_half: assert property (p_warm_half) else $error("warm half current wrong");

   property p_no_double;
      @(posedge clock_i) disable iff (!resetn_i) zone_warm_i |=> !timer_double_o;
   endproperty
   a_no_double: assert property (p_no_double) else $error("timer doubled in warm zone");

   property p_pulse_gate;
      @(posedge clock_i) disable iff (!resetn_i)
         wr_pulse && !reg_wdata_i[`F_PULSE_ALLOW] && !defaults |=> ##1 !pulse_raise_o && !pulse_lower_o;
   endproperty
   a_pulse_gate: assert property (p_pulse_gate) else $error("pulse request set while disallowed");

   property p_pulse_clear;
      @(posedge clock_i) disable iff (!resetn_i)
         pulse_done_i && !wr_pulse |=> pulse_and_usb_line_config_r[`F_PULSE_RAISE:`F_PULSE_LOWER] == 2'h0;
   endproperty
   a_pulse_clear: assert property (p_pulse_clear) else $error("pulse request not cleared");

   property p_plugin;
      @(posedge clock_i) disable iff (!resetn_i) source_plugin_i |=> ##1 dplus_level_o == 2'h0 && dminus_level_o == 2'h0;
   endproperty
   a_plugin: assert property (p_plugin) else $error("line levels kept after plug-in");

   property p_detect;
      @(posedge clock_i) disable iff (!resetn_i) detect_finish_i |=> source_detect_complete_r;
   endproperty
   a_detect: assert property (p_detect) else $error("detect done not set");

   property p_regrst;
      @(posedge clock_i) disable iff (!resetn_i)
         reg_reset_i |=> timer_restart_o && temp_zone_charge_config_r == `RST_TEMP_ZONE
         && trim_and_pin_config_r == `RST_TRIM_PIN;
   endproperty
   a_regrst: assert property (p_regrst) else $error("register reset incomplete");

   property p_wd_offset;
      @(posedge clock_i) disable iff (!resetn_i)
         watchdog_expire_i && !reg_reset_i && !wr_trim |=>
         $stable(trim_and_pin_config_r[`F_OFFSET_HI:`F_OFFSET_LO])
         ##1 input_offset_o == $past(trim_and_pin_config_r[`F_OFFSET_HI:`F_OFFSET_LO]);
   endproperty
   a_wd_offset: assert property (p_wd_offset) else $error("offset lost on watchdog");

   c_pulse_done: cover property (@(posedge clock_i) disable iff (!resetn_i) pulse_raise_o ##1 pulse_done_i);
   c_detect: cover property (@(posedge clock_i) disable iff (!resetn_i) force_detect_i ##[1:20] detect_finish_i);
   c_cool_cap: cover property (@(posedge clock_i) disable iff (!resetn_i) zone_cool_i && charge_mv_o == `VCAP_MV);
endmodule

// file: design/charger_regs.svh
// register offsets, field positions, reset values and timing counts
// of the charger configuration bank; included by the design files
`ifndef CHARGER_REGS_SVH
`define CHARGER_REGS_SVH

// register offsets
`define OFS_TEMP_ZONE 8'h0C
`define OFS_PULSE_LINE 8'h0D
`define OFS_DETECT 8'h0E
`define OFS_TRIM_PIN 8'h0F

// reset values
`define RST_TEMP_ZONE 8'h75
`define RST_PULSE_LINE 8'h01
`define RST_TRIM_PIN 8'h00

// temp zone register fields
`define F_VCAP 7
`define F_COOL_ALLOW 6
`define F_WARM_HI 5
`define F_WARM_LO 4
`define F_COOL_TH_HI 3
`define F_COOL_TH_LO 2
`define F_WARM_TH_HI 1
`define F_WARM_TH_LO 0

// pulse and line register fields
`define F_PULSE_ALLOW 7
`define F_PULSE_RAISE 6
`define F_PULSE_LOWER 5
`define F_DPLUS_HI 4
`define F_DPLUS_LO 3
`define F_DMINUS_HI 2
`define F_DMINUS_LO 1
`define F_FREQ_RANGE 0

// detect status and trim register fields
`define F_DETECT_DONE 7
`define F_TRIM_HI 7
`define F_TRIM_LO 6
`define F_TRICKLE 4
`define F_STAT_HI 3
`define F_STAT_LO 2
`define F_OFFSET_HI 1
`define F_OFFSET_LO 0

// analog figures in mV and mA
`define VCAP_MV 13'h1004
`define TRIM_STEP_MV 13'h0008
`define TERM_RANGE_MULT 13'h0006
`define TERM_RANGE_MIN_MA 13'h012C
`define TRICKLE_HIGH_MA 7'h5A
`define TRICKLE_LOW_MA 7'h1E

// status pin blink timing
`define CLK_KHZ 250000
`define BLINK_ON_MS 1000
`define BLINK_OFF_SHORT_MS 1000
`define BLINK_OFF_LONG_MS 3000
`define BLINK_ON_CYCLES (`BLINK_ON_MS * `CLK_KHZ)
`define BLINK_OFF_SHORT_CYCLES (`BLINK_OFF_SHORT_MS * `CLK_KHZ)
`define BLINK_OFF_LONG_CYCLES (`BLINK_OFF_LONG_MS * `CLK_KHZ)

`endif

// file: design/charger_pkg.sv
// types shared by the charger configuration bank
// no assumptions beyond a SystemVerilog compiler
package charger_pkg;
   typedef logic [1:0] code2_t;
   typedef enum logic [1:0] {PAT_OFF, PAT_LOW, PAT_BLINK_SHORT, PAT_BLINK_LONG} stat_pattern_t;
   typedef enum {BLINK_ON, BLINK_OFF} blink_state_t;
endpackage

// file: design/stat_pin_if.sv
// status pin control passed between the bank and the blinker
// both ends run on the same clock
`timescale 1ns/1ps
interface stat_pin_if;
   charger_pkg::stat_pattern_t pattern;
   logic active;
   logic pin_oe;
   logic pin_out;
   modport bank(output pattern, output active, input pin_oe, input pin_out);
   modport led(input pattern, input active, output pin_oe, output pin_out);
endinterface

// file: design/stat_blinker.sv
// open-drain status pin pattern generator
// assumes a synchronous active-low reset and one clock
`timescale 1ns/1ps
`include "charger_regs.svh"
module stat_blinker #(
   parameter int unsigned ON_CYCLES = `BLINK_ON_CYCLES,
   parameter int unsigned OFF_SHORT_CYCLES = `BLINK_OFF_SHORT_CYCLES,
   parameter int unsigned OFF_LONG_CYCLES = `BLINK_OFF_LONG_CYCLES
) (
   input wire logic clock_i,
   input wire logic resetn_i,
   stat_pin_if.led ctl
);
   charger_pkg::blink_state_t state_r;
   logic [31:0] count_r;
   logic [31:0] limit;
   logic blinking;

   // length of the current blink phase
   always_comb begin
      blinking = ctl.active && (ctl.pattern == charger_pkg::PAT_BLINK_SHORT ||
                                ctl.pattern == charger_pkg::PAT_BLINK_LONG);
      if (state_r == charger_pkg::BLINK_ON) begin
         limit = ON_CYCLES;
      end else if (ctl.pattern == charger_pkg::PAT_BLINK_LONG) begin
         limit = OFF_LONG_CYCLES;
      end else begin
         limit = OFF_SHORT_CYCLES;
      end
   end

   // phase counter, restarts in the on phase whenever blinking stops
   always_ff @(posedge clock_i) begin
      if (!resetn_i || !blinking) begin
         state_r <= charger_pkg::BLINK_ON;
         count_r <= 32'h00000000;
      end else if (count_r >= limit - 32'h00000001) begin
         count_r <= 32'h00000000;
         unique case (state_r)
            charger_pkg::BLINK_ON: state_r <= charger_pkg::BLINK_OFF;
            charger_pkg::BLINK_OFF: state_r <= charger_pkg::BLINK_ON;
         endcase
      end else begin
         count_r <= count_r + 32'h00000001;
      end
   end

   // pin pulls low only when lit; pattern ignored unless active
   always_ff @(posedge clock_i) begin
      if (!resetn_i) begin
         ctl.pin_oe <= 1'b0;
      end else if (!ctl.active) begin
         ctl.pin_oe <= 1'b0;
      end else begin
         unique case (ctl.pattern)
            charger_pkg::PAT_OFF: ctl.pin_oe <= 1'b0;
            charger_pkg::PAT_LOW: ctl.pin_oe <= 1'b1;
            default: ctl.pin_oe <= (state_r == charger_pkg::BLINK_ON);
         endcase
      end
   end

   // driven level is always low; the pin floats when not enabled
   always_ff @(posedge clock_i) begin
      ctl.pin_out <= 1'b0;
   end

   property p_stat_inactive;
      @(posedge clock_i) disable iff (!resetn_i) !ctl.active |=> !ctl.pin_oe;
   endproperty
   a_stat_inactive: assert property (p_stat_inactive) else $error("status pin driven while inactive");

   property p_stat_low;
      @(posedge clock_i) disable iff (!resetn_i)
         ctl.active && ctl.pattern == charger_pkg::PAT_LOW |=> ctl.pin_oe;
   endproperty
   a_stat_low: assert property (p_stat_low) else $error("status pin not low in low pattern");

   c_stat_blink: cover property (@(posedge clock_i) disable iff (!resetn_i)
      ctl.pin_oe ##1 !ctl.pin_oe && blinking);
endmodule

// file: tb/host_model.sv
// host processor side of the register bus: single-byte reads and writes
// assumes the bench drives nothing else on these lines
`timescale 1ns/1ps
module host_model (
   input wire logic clock_i,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   input wire logic [7:0] rdata_i
);
   // idle bus at time zero
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end

   // one write strobe held across a single rising edge
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock_i);
      #1;
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(posedge clock_i);
      #1;
      wr_o = 1'b0;
      addr_o = ~a; // released lines show no stale value
      wdata_o = ~d;
   endtask

   // read strobe, data taken one cycle after the strobe edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock_i);
      #1;
      addr_o = a;
      rd_o = 1'b1;
      @(posedge clock_i);
      #1;
      rd_o = 1'b0;
      addr_o = ~a;
      @(posedge clock_i);
      #1;
      d = rdata_i;
   endtask
endmodule

// file: tb/tb_top.sv
// self-checking bench for the charger configuration bank
// assumes the host model drives the register strobes
`timescale 1ns/1ps
module tb_top;
   logic clock_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, rv;
   logic reg_wr_i, reg_rd_i;
   logic reg_reset_i = 1'b0, watchdog_expire_i = 1'b0, zone_cool_i = 1'b0, zone_warm_i = 1'b0;
   logic boost_mode_i = 1'b0, timer_double_req_i = 1'b0, pulse_done_i = 1'b0, source_plugin_i = 1'b0;
   logic force_detect_i = 1'b0, detect_finish_i = 1'b0;
   logic [12:0] target_mv_i = 13'h1068, charge_current_setting_ma_i = 13'h03E8, termination_current_setting_ma_i = 13'h0064;
   logic [1:0] monitor_select_i = 2'h1;
   logic [12:0] charge_mv_o, charge_ma_o, term_ma_o;
   logic [6:0] trickle_ma_o;
   logic timer_double_o, timer_restart_o, pulse_allow_o, pulse_raise_o, pulse_lower_o;
   logic [1:0] cool_select_o, warm_select_o, dplus_level_o, dminus_level_o, input_offset_o;
   logic boost_fast_o, stat_out_o, stat_oe_o;
   int errors = 0, n_tests = 0, cycles = 0, hi;

   charger_config_regs_0c_0f #(.BLINK_ON_CYCLES(4), .BLINK_OFF_SHORT_CYCLES(4), .BLINK_OFF_LONG_CYCLES(12))
   charger_config_regs_0c_0f_inst (.clock_i, .resetn_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
      .reg_rdata_o, .reg_reset_i, .watchdog_expire_i, .zone_cool_i, .zone_warm_i, .boost_mode_i,
      .target_mv_i, .charge_current_setting_ma_i, .termination_current_setting_ma_i, .timer_double_req_i, .pulse_done_i, .source_plugin_i,
      .force_detect_i, .detect_finish_i, .monitor_select_i, .charge_mv_o, .charge_ma_o, .term_ma_o,
      .trickle_ma_o, .timer_double_o, .timer_restart_o, .cool_select_o, .warm_select_o, .pulse_allow_o,
      .pulse_raise_o, .pulse_lower_o, .dplus_level_o, .dminus_level_o, .boost_fast_o, .input_offset_o,
      .stat_out_o, .stat_oe_o);
   host_model host_model_inst (.clock_i, .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .wr_o(reg_wr_i),
      .rd_o(reg_rd_i), .rdata_i(reg_rdata_o));

   // 4 ns clock
   initial begin
      forever #2 clock_i = ~clock_i;
   end

   // hang guard
   always @(posedge clock_i) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         finish_test();
      end
   end

   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // settle n edges, then step past the edge
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask

   task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
      host_model_inst.rd(a, rv);
      check({5'h00, rv}, {5'h00, exp});
   endtask

   task automatic wrs(input logic [7:0] a, input logic [7:0] d);
      host_model_inst.wr(a, d);
      tick(2);
   endtask

   // reset values and unmapped access
   task automatic t_reset();
      rdc(8'h0C, 8'h75);
      rdc(8'h0D, 8'h01);
      rdc(8'h0F, 8'h00);
      host_model_inst.wr(8'h10, 8'hFF);
      rdc(8'h10, 8'h00);
      check(cool_select_o, 13'h1);
      check(warm_select_o, 13'h1);
      check(boost_fast_o, 13'h1);
      check(trickle_ma_o, 13'h5A);
      check(dplus_level_o, 13'h0);
      check(dminus_level_o, 13'h0);
   endtask

   // temperature zone voltage, current and threshold fields
   task automatic t_zones();
      logic [12:0] sc[4];
      sc = '{13'h0000, 13'h00C8, 13'h01F4, 13'h03E8};
      for (int k = 0; k < 4; k++) begin
         wrs(8'h0C, {4'h7, k[1:0], ~k[1:0]});
         check(cool_select_o, k);
         check(warm_select_o, 3 - k);
      end
      zone_cool_i = 1'b1;
      wrs(8'h0C, 8'hC5);
      check(charge_mv_o, 13'h1004);
      check(charge_ma_o, 13'h03E8);
      wrs(8'h0C, 8'h45);
      check(charge_mv_o, 13'h1068);
      wrs(8'h0C, 8'h05);
      check(charge_ma_o, 13'h0000);
      zone_cool_i = 1'b0;
      zone_warm_i = 1'b1;
      timer_double_req_i = 1'b1;
      for (int k = 0; k < 4; k++) begin
         wrs(8'h0C, {2'h1, k[1:0], 4'h5});
         check(charge_ma_o, sc[k]);
         check(timer_double_o, 13'h0);
      end
      zone_warm_i = 1'b0;
      tick(2);
      check(timer_double_o, 13'h1);
      timer_double_req_i = 1'b0;
   endtask

   // pulse requests gated by the allow bit and cleared when done
   task automatic t_pulse();
      wrs(8'h0D, 8'h41);
      check(pulse_raise_o, 13'h0);
      rdc(8'h0D, 8'h01);
      wrs(8'h0D, 8'hC1);
      check(pulse_allow_o, 13'h1);
      check(pulse_raise_o, 13'h1);
      pulse_done_i = 1'b1;
      tick(1);
      pulse_done_i = 1'b0;
      tick(2);
      check(pulse_raise_o, 13'h0);
      rdc(8'h0D, 8'h81);
      wrs(8'h0D, 8'hA1);
      check(pulse_lower_o, 13'h1);
      pulse_done_i = 1'b1;
      tick(1);
      pulse_done_i = 1'b0;
      tick(2);
      check(pulse_lower_o, 13'h0);
   endtask

   // detection flag and line levels, both cleared by a later plug-in
   task automatic t_lines();
      source_plugin_i = 1'b1;
      tick(1);
      source_plugin_i = 1'b0;
      force_detect_i = 1'b1;
      tick(1);
      force_detect_i = 1'b0;
      rdc(8'h0E, 8'h00);
      detect_finish_i = 1'b1;
      tick(1);
      detect_finish_i = 1'b0;
      rdc(8'h0E, 8'h80);
      host_model_inst.wr(8'h0E, 8'h00);
      rdc(8'h0E, 8'h80);
      for (int k = 0; k < 4; k++) begin
         wrs(8'h0D, {3'h0, k[1:0], ~k[1:0], 1'b1});
         check(dplus_level_o, k);
         check(dminus_level_o, 3 - k);
      end
      source_plugin_i = 1'b1;
      tick(1);
      source_plugin_i = 1'b0;
      tick(2);
      check({dplus_level_o, dminus_level_o}, 13'h0);
      rdc(8'h0E, 8'h00);
   endtask

   // shared frequency and termination range bit
   task automatic t_range();
      charge_current_setting_ma_i = 13'h01F4;
      wrs(8'h0D, 8'h00);
      check(boost_fast_o, 13'h0);
      check(term_ma_o, 13'h0258);
      charge_current_setting_ma_i = 13'h012C;
      tick(2);
      check(term_ma_o, 13'h0064);
      charge_current_setting_ma_i = 13'h03E8;
      boost_mode_i = 1'b1;
      tick(2);
      check(term_ma_o, 13'h0064);
      boost_mode_i = 1'b0;
      wrs(8'h0D, 8'h01);
      check(term_ma_o, 13'h0064);
   endtask

   // trim, trickle, status pin patterns and offset
   task automatic t_trim();
      logic [12:0] tv[4];
      tv = '{13'h1068, 13'h1070, 13'h1060, 13'h1058};
      for (int k = 0; k < 4; k++) begin
         wrs(8'h0F, {k[1:0], 2'h1, 2'h1, k[1:0]});
         check(charge_mv_o, tv[k]);
         check(trickle_ma_o, 13'h1E);
         check(input_offset_o, k);
         check(stat_oe_o, 13'h1);
      end
      monitor_select_i = 2'h0;
      tick(2);
      check(stat_oe_o, 13'h0);
      monitor_select_i = 2'h1;
      for (int k = 2; k < 4; k++) begin
         wrs(8'h0F, {4'h0, k[1:0], 2'h0});
         hi = 0;
         repeat (16 * (k - 1)) begin
            tick(1);
            hi += stat_oe_o;
         end
         check(hi, 13'h8);
      end
      check(stat_out_o, 13'h0);
   endtask

   // watchdog keeps the offset, register reset clears 0x0F and the offset and pulses the timer restart
   task automatic t_restore();
      wrs(8'h0C, 8'h00);
      wrs(8'h0F, 8'hFF);
      watchdog_expire_i = 1'b1;
      tick(1);
      watchdog_expire_i = 1'b0;
      rdc(8'h0C, 8'h75);
      rdc(8'h0F, 8'h03);
      check(stat_oe_o, 13'h0);
      reg_reset_i = 1'b1;
      tick(1);
      reg_reset_i = 1'b0;
      check(timer_restart_o, 13'h1);
      tick(1);
      check(timer_restart_o, 13'h0);
      rdc(8'h0F, 8'h00);
      check(input_offset_o, 13'h0);
   endtask

   // main sequence
   initial begin
      tick(8);
      resetn_i = 1'b1;
      t_reset();
      t_zones();
      t_pulse();
      t_lines();
      t_range();
      t_trim();
      t_restore();
      finish_test();
   end
endmodule
